// ==== logic/vio_map.sv ====
// register file and top level of the virtual input/output mapping block
//
// Summary of operation
// - trigger zero: function active while input high
// - trigger one: function fires on input rise
// - polarity zero: output high while function active
// - polarity one: output low while function active
// - sixteen inputs, codes 0-37; outputs, codes 0-19
//
// Chosen here: the APB slave port and the address map.
module vio_map (
  input  wire logic                            pclk,
  input  wire logic                            presetn,
  input  wire logic                            psel,
  input  wire logic                            penable,
  input  wire logic                            pwrite,
  input  wire logic [vio_pkg::APB_ADDR_W-1:0]  paddr,
  input  wire logic [31:0]                     pwdata,
  output logic      [31:0]                     prdata,
  output logic                                 pready,
  output logic                                 pslverr,
  input  wire logic                            drive_running,
  input  wire logic [vio_pkg::NUM_VIN-1:0]     virtual_input,
  input  wire logic [vio_pkg::VOUT_CODES-1:0]  status_active,
  output logic      [vio_pkg::VIN_CODES-1:0]  function_active,
  output logic      [vio_pkg::NUM_VOUT-1:0]    virtual_output
);

  // ==========================================================================
  // address decode
  function automatic vio_pkg::reg_sel_t decode(input logic [vio_pkg::APB_ADDR_W-1:0] addr);
    vio_pkg::reg_sel_t sel;
    vio_pkg::reg_idx_t idx;
    vio_pkg::reg_idx_t off;
    sel.kind = vio_pkg::reg_none;
    sel.chan = 4'h0;
    idx      = addr[vio_pkg::APB_ADDR_W-1:2];
    off      = idx - vio_pkg::IDX_VOUT_BASE;
    if (addr[1:0] != 2'h0) begin
      sel.kind = vio_pkg::reg_none;
    end else if (idx < vio_pkg::IDX_VOUT_VIEW) begin
      sel.kind = idx[0] ? vio_pkg::reg_vin_trig : vio_pkg::reg_vin_func;
      sel.chan = idx[4:1];
    end else if (idx == vio_pkg::IDX_VOUT_VIEW) begin
      sel.kind = vio_pkg::reg_vout_view;
    end else if (idx >= vio_pkg::IDX_VOUT_BASE && off < 6'(2 * vio_pkg::NUM_VOUT)) begin
      sel.kind = off[0] ? vio_pkg::reg_vout_pol : vio_pkg::reg_vout_func;
      sel.chan = off[4:1];
    end else if (idx == vio_pkg::IDX_STATUS) begin
      sel.kind = vio_pkg::reg_status;
    end
    return sel;
  endfunction

  // ==========================================================================
  // written settings, held apart from the applied ones
  vio_pkg::vin_code_t  vin_func_sh [vio_pkg::NUM_VIN];
  logic                vin_trig_sh [vio_pkg::NUM_VIN];
  vio_pkg::vout_code_t vout_func_sh[vio_pkg::NUM_VOUT];
  logic                vout_pol_sh [vio_pkg::NUM_VOUT];

  map_cfg_if cfg ();

  vio_pkg::reg_sel_t sel;
  logic              access;
  logic              wr_access;
  logic              setup_rd;
  logic              bad_value;
  logic              wr_ok;
  logic              pending;
  logic [31:0]       next_prdata;

  assign sel       = decode(paddr);
  assign access    = psel & penable;
  assign wr_access = access & pwrite;
  assign setup_rd  = psel & ~penable & ~pwrite;

  // out-of-range codes and writes to read-only words are refused, not clipped
  always_comb begin
    case (sel.kind)
      vio_pkg::reg_vin_func:  bad_value = pwdata >= 32'(vio_pkg::VIN_CODES);
      vio_pkg::reg_vout_func: bad_value = pwdata >= 32'(vio_pkg::VOUT_CODES);
      vio_pkg::reg_vin_trig,
      vio_pkg::reg_vout_pol:  bad_value = pwdata > 32'h0000_0001;
      default:                bad_value = 1'b1;
    endcase
  end

  assign wr_ok   = wr_access & ~bad_value;
  // zero wait states: every access ends in its first access cycle
  assign pready  = 1'b1;
  assign pslverr = access & ((sel.kind == vio_pkg::reg_none) | (pwrite & bad_value));

  // ==========================================================================
  // setting storage, written at the access edge
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < vio_pkg::NUM_VIN; i++) begin
        vin_func_sh[i] <= vio_pkg::VIN_FUNC_RESET;
        vin_trig_sh[i] <= vio_pkg::TRIG_LEVEL;
      end
      for (int i = 0; i < vio_pkg::NUM_VOUT; i++) begin
        vout_func_sh[i] <= vio_pkg::VOUT_FUNC_RESET;
        vout_pol_sh[i]  <= vio_pkg::POL_ACTIVE_HIGH;
      end
    end else if (wr_ok) begin
      // writes land at any time, whether the drive runs or not
      case (sel.kind)
        vio_pkg::reg_vin_func:  vin_func_sh[sel.chan]                           <= pwdata[5:0];
        vio_pkg::reg_vin_trig:  vin_trig_sh[sel.chan]                           <= pwdata[0];
        vio_pkg::reg_vout_func: vout_func_sh[sel.chan[$clog2(vio_pkg::NUM_VOUT)-1:0]] <= pwdata[4:0];
        vio_pkg::reg_vout_pol:  vout_pol_sh[sel.chan[$clog2(vio_pkg::NUM_VOUT)-1:0]]  <= pwdata[0];
        default: begin
        end
      endcase
    end
  end

  // ==========================================================================
  // applied settings: copied only while the drive stands still, so a running
  // axis never sees its inputs or outputs re-bound under it
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < vio_pkg::NUM_VIN; i++) begin
        cfg.vin_func[i] <= vio_pkg::VIN_FUNC_RESET;
        cfg.vin_trig[i] <= vio_pkg::TRIG_LEVEL;
      end
      for (int i = 0; i < vio_pkg::NUM_VOUT; i++) begin
        cfg.vout_func[i] <= vio_pkg::VOUT_FUNC_RESET;
        cfg.vout_pol[i]  <= vio_pkg::POL_ACTIVE_HIGH;
      end
    end else if (!drive_running) begin
      for (int i = 0; i < vio_pkg::NUM_VIN; i++) begin
        cfg.vin_func[i] <= vin_func_sh[i];
        cfg.vin_trig[i] <= vin_trig_sh[i];
      end
      for (int i = 0; i < vio_pkg::NUM_VOUT; i++) begin
        cfg.vout_func[i] <= vout_func_sh[i];
        cfg.vout_pol[i]  <= vout_pol_sh[i];
      end
    end
  end

  always_comb begin
    pending = 1'b0;
    for (int i = 0; i < vio_pkg::NUM_VIN; i++) begin
      pending |= (cfg.vin_func[i] != vin_func_sh[i]) | (cfg.vin_trig[i] != vin_trig_sh[i]);
    end
    for (int i = 0; i < vio_pkg::NUM_VOUT; i++) begin
      pending |= (cfg.vout_func[i] != vout_func_sh[i]) | (cfg.vout_pol[i] != vout_pol_sh[i]);
    end
  end

  // ==========================================================================
  // read path: data is captured in the setup cycle and held through access
  always_comb begin
    next_prdata = 32'h0000_0000;
    case (sel.kind)
      vio_pkg::reg_vin_func:  next_prdata[5:0] = vin_func_sh[sel.chan];
      vio_pkg::reg_vin_trig:  next_prdata[0]   = vin_trig_sh[sel.chan];
      vio_pkg::reg_vout_view: next_prdata[vio_pkg::NUM_VOUT-1:0] = virtual_output;
      vio_pkg::reg_vout_func: next_prdata[4:0] = vout_func_sh[sel.chan[$clog2(vio_pkg::NUM_VOUT)-1:0]];
      vio_pkg::reg_vout_pol:  next_prdata[0]   = vout_pol_sh[sel.chan[$clog2(vio_pkg::NUM_VOUT)-1:0]];
      vio_pkg::reg_status: begin
        next_prdata[vio_pkg::STAT_RUN_BIT]     = drive_running;
        next_prdata[vio_pkg::STAT_PENDING_BIT] = pending;
      end
      default: next_prdata = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (setup_rd) begin
      prdata <= next_prdata;
    end
  end

  // ==========================================================================
  // mappers
  vin_map #(
    .NUM_IN    (vio_pkg::NUM_VIN),
    .NUM_CODES (vio_pkg::VIN_CODES)
  ) u_vin_map (
    .pclk        (pclk),
    .presetn     (presetn),
    .cfg         (cfg),
    .level       (virtual_input),
    .func_active (function_active)
  );

  vout_map #(
    .NUM_OUT   (vio_pkg::NUM_VOUT),
    .NUM_CODES (vio_pkg::VOUT_CODES)
  ) u_vout_map (
    .pclk          (pclk),
    .presetn       (presetn),
    .cfg           (cfg),
    .status_active (status_active),
    .level         (virtual_output)
  );

  // ==========================================================================
  // checks
  for (genvar g = 0; g < vio_pkg::NUM_VIN; g++) begin : g_vin_chk
    run_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
      drive_running |=> $stable(cfg.vin_func[g]) && $stable(cfg.vin_trig[g]))
      else $error("input mapping changed while the drive ran");
    stop_apply_a: assert property (@(posedge pclk) disable iff (!presetn)
      !drive_running |=> cfg.vin_func[g] == $past(vin_func_sh[g]))
      else $error("input mapping not applied while stopped");
  end

  for (genvar g = 0; g < vio_pkg::NUM_VOUT; g++) begin : g_vout_chk
    out_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
      drive_running |=> $stable(cfg.vout_func[g]) && $stable(cfg.vout_pol[g]))
      else $error("output mapping changed while the drive ran");
  end

  range_refuse_a: assert property (@(posedge pclk) disable iff (!presetn)
    wr_access && sel.kind == vio_pkg::reg_vin_func && pwdata >= 32'(vio_pkg::VIN_CODES)
    |-> pslverr ##1 vin_func_sh[$past(sel.chan)] == $past(vin_func_sh[sel.chan]))
    else $error("out-of-range input code was accepted");

  write_store_a: assert property (@(posedge pclk) disable iff (!presetn)
    wr_access && sel.kind == vio_pkg::reg_vout_func && pwdata < 32'(vio_pkg::VOUT_CODES)
    |=> vout_func_sh[$past(sel.chan[1:0])] == $past(pwdata[4:0]))
    else $error("valid output code was not stored");

  view_read_a: assert property (@(posedge pclk) disable iff (!presetn)
    setup_rd && sel.kind == vio_pkg::reg_vout_view
    |=> prdata[vio_pkg::NUM_VOUT-1:0] == $past(virtual_output) && pready)
    else $error("output level view read back wrong");

endmodule

// ==== logic/vio_pkg.sv ====
// shared constants and types for the virtual input/output mapping block
package vio_pkg;

  // ==========================================================================
  // sizes
  localparam int NUM_VIN    = 16;
  localparam int NUM_VOUT   = 4;
  localparam int VIN_CODES  = 38;
  localparam int VOUT_CODES = 20;
  localparam int APB_ADDR_W = 8;
  localparam int REG_W      = 16;

  typedef logic [5:0] vin_code_t;
  typedef logic [4:0] vout_code_t;
  typedef logic [5:0] reg_idx_t;

  // ==========================================================================
  // register indices; byte address is four times the index
  localparam reg_idx_t IDX_VIN_BASE  = 6'h00;
  localparam reg_idx_t IDX_VOUT_VIEW = 6'h20;
  localparam reg_idx_t IDX_VOUT_BASE = 6'h21;
  localparam reg_idx_t IDX_STATUS    = 6'h30;

  // status register bit positions
  localparam int STAT_RUN_BIT     = 0;
  localparam int STAT_PENDING_BIT = 1;

  // ==========================================================================
  // reset values and encodings
  localparam vin_code_t  VIN_FUNC_RESET  = 6'h00;
  localparam vout_code_t VOUT_FUNC_RESET = 5'h00;
  localparam logic       TRIG_LEVEL      = 1'b0;
  localparam logic       TRIG_RISE       = 1'b1;
  localparam logic       POL_ACTIVE_HIGH = 1'b0;
  localparam logic       POL_ACTIVE_LOW  = 1'b1;
  localparam vin_code_t  VIN_CODE_NONE   = 6'h00;
  localparam vout_code_t VOUT_CODE_NONE  = 5'h00;

  typedef enum logic [2:0] {
    reg_none,
    reg_vin_func,
    reg_vin_trig,
    reg_vout_view,
    reg_vout_func,
    reg_vout_pol,
    reg_status
  } reg_kind_t;

  typedef struct packed {
    reg_kind_t   kind;
    logic [3:0]  chan;
  } reg_sel_t;

endpackage

// ==== logic/map_cfg_if.sv ====
// applied mapping settings carried from the register file to the mappers
interface map_cfg_if;
  vio_pkg::vin_code_t  vin_func [vio_pkg::NUM_VIN];
  logic                vin_trig [vio_pkg::NUM_VIN];
  vio_pkg::vout_code_t vout_func[vio_pkg::NUM_VOUT];
  logic                vout_pol [vio_pkg::NUM_VOUT];

  modport src  (output vin_func, output vin_trig, output vout_func, output vout_pol);
  modport sink (input  vin_func, input  vin_trig, input  vout_func, input  vout_pol);
endinterface

// ==== logic/vin_map.sv ====
// binds each virtual input to its drive function, by level or by rising edge
module vin_map #(
  parameter int NUM_IN    = vio_pkg::NUM_VIN,
  parameter int NUM_CODES = vio_pkg::VIN_CODES
) (
  input  wire logic                 pclk,
  input  wire logic                 presetn,
  map_cfg_if.sink                   cfg,
  input  wire logic [NUM_IN-1:0]    level,
  output logic      [NUM_CODES-1:0] func_active
);

  logic [NUM_IN-1:0]    level_q;
  logic [NUM_IN-1:0]    hit;
  logic [NUM_CODES-1:0] next_active;

  // ==========================================================================
  // edge memory; a high input right after reset counts as a rise
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      level_q <= '0;
    end else begin
      level_q <= level;
    end
  end

  always_comb begin
    next_active = '0;
    hit         = '0;
    for (int i = 0; i < NUM_IN; i++) begin
      if (cfg.vin_trig[i] == vio_pkg::TRIG_LEVEL) begin
        hit[i] = level[i];
      end else begin
        hit[i] = level[i] & ~level_q[i];
      end
      // several inputs on one code are or-ed together
      if (hit[i] && cfg.vin_func[i] != vio_pkg::VIN_CODE_NONE) begin
        next_active[cfg.vin_func[i]] = 1'b1;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      func_active <= '0;
    end else begin
      func_active <= next_active;
    end
  end

  // ==========================================================================
  // checks
  for (genvar g = 0; g < NUM_IN; g++) begin : g_chk
    level_follow_a: assert property (@(posedge pclk) disable iff (!presetn)
      cfg.vin_trig[g] == vio_pkg::TRIG_LEVEL && cfg.vin_func[g] != vio_pkg::VIN_CODE_NONE && level[g]
      |=> func_active[$past(cfg.vin_func[g])])
      else $error("level input did not activate its function");
    rise_pulse_a: assert property (@(posedge pclk) disable iff (!presetn)
      cfg.vin_trig[g] == vio_pkg::TRIG_RISE && cfg.vin_func[g] != vio_pkg::VIN_CODE_NONE
      && level[g] && !level_q[g]
      |=> func_active[$past(cfg.vin_func[g])])
      else $error("rising input did not activate its function");
  end

endmodule

// ==== logic/vout_map.sv ====
// drives each virtual output from its selected status function and polarity
module vout_map #(
  parameter int NUM_OUT   = vio_pkg::NUM_VOUT,
  parameter int NUM_CODES = vio_pkg::VOUT_CODES
) (
  input  wire logic                 pclk,
  input  wire logic                 presetn,
  map_cfg_if.sink                   cfg,
  input  wire logic [NUM_CODES-1:0] status_active,
  output logic      [NUM_OUT-1:0]   level
);

  logic [NUM_OUT-1:0] next_level;

  always_comb begin
    for (int i = 0; i < NUM_OUT; i++) begin
      // code zero selects nothing, so the output rests at its inactive level
      next_level[i] = cfg.vout_pol[i]
                    ^ (cfg.vout_func[i] != vio_pkg::VOUT_CODE_NONE && status_active[cfg.vout_func[i]]);
    end
  end

  // reset value is the inactive level for polarity zero
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      level <= '0;
    end else begin
      level <= next_level;
    end
  end

  for (genvar g = 0; g < NUM_OUT; g++) begin : g_chk
    pol_high_a: assert property (@(posedge pclk) disable iff (!presetn)
      cfg.vout_pol[g] == vio_pkg::POL_ACTIVE_HIGH && cfg.vout_func[g] != vio_pkg::VOUT_CODE_NONE
      && status_active[cfg.vout_func[g]] |=> level[g])
      else $error("active-high output not driven high");
    pol_low_a: assert property (@(posedge pclk) disable iff (!presetn)
      cfg.vout_pol[g] == vio_pkg::POL_ACTIVE_LOW && cfg.vout_func[g] != vio_pkg::VOUT_CODE_NONE
      && status_active[cfg.vout_func[g]] |=> !level[g])
      else $error("active-low output not driven low");
  end

endmodule

// ==== tb/tb_vio_map.sv ====
// self-checking testbench for the virtual input/output mapping block
module tb_vio_map;
  timeunit 1ns;
  timeprecision 1ps;

  // ==========================================================================
  // signals
  logic                               pclk;
  logic                               presetn;
  logic                               psel;
  logic                               penable;
  logic                               pwrite;
  logic [vio_pkg::APB_ADDR_W-1:0]     paddr;
  logic [31:0]                        pwdata;
  logic [31:0]                        prdata;
  logic                               pready;
  logic                               pslverr;
  logic                               drive_running;
  logic [vio_pkg::NUM_VIN-1:0]        virtual_input;
  logic [vio_pkg::VOUT_CODES-1:0]     status_active;
  logic [vio_pkg::VIN_CODES-1:0]      function_active;
  logic [vio_pkg::NUM_VOUT-1:0]       virtual_output;
  int                                 n_errors;
  int                                 num_checks;
  int                                 cycles;

  vio_map DUT (
    .pclk            (pclk),
    .presetn         (presetn),
    .psel            (psel),
    .penable         (penable),
    .pwrite          (pwrite),
    .paddr           (paddr),
    .pwdata          (pwdata),
    .prdata          (prdata),
    .pready          (pready),
    .pslverr         (pslverr),
    .drive_running   (drive_running),
    .virtual_input   (virtual_input),
    .status_active   (status_active),
    .function_active (function_active),
    .virtual_output  (virtual_output)
  );

  always #5 pclk = ~pclk;

  // ==========================================================================
  // reporting
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  task automatic check(input string what, input logic [63:0] seen, input logic [63:0] exp);
    num_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // the whole run needs a few hundred cycles; a hang ends here
  always @(posedge pclk) begin
    cycles <= cycles + 1;
    if (cycles > 20000) begin
      n_errors++;
      print_verdict();
    end
  end

  // ==========================================================================
  // apb master
  task automatic apb(input logic wr, input logic [7:0] addr, input logic [31:0] wd,
                     output logic [31:0] rd, output logic err);
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= addr;
    pwdata  <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    // no wait-state count is assumed; only the bench timeout ends a wait
    while (pready !== 1'b1) begin
      @(posedge pclk);
    end
    rd  = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic write_reg(input logic [5:0] idx, input logic [31:0] d, output logic err);
    logic [31:0] rd;
    apb(1'b1, {idx, 2'b00}, d, rd, err);
  endtask

  task automatic read_reg(input logic [5:0] idx, output logic [31:0] d, output logic err);
    apb(1'b0, {idx, 2'b00}, 32'h0, d, err);
  endtask

  // ==========================================================================
  // scenarios
  task automatic test_reset_values();
    logic [31:0] d;
    logic        e;
    check("function_active at reset", function_active, 64'h0);
    check("virtual_output at reset", virtual_output, 64'h0);
    for (int i = 0; i <= 8'h28; i++) begin
      read_reg(i[5:0], d, e);
      check("reset value", d, 64'h0);
      check("reset read error", e, 64'h0);
    end
    read_reg(vio_pkg::IDX_STATUS, d, e);
    check("status at reset", d, 64'h0);
  endtask

  task automatic test_refusals();
    logic [31:0] d;
    logic        e;
    write_reg(vio_pkg::IDX_VIN_BASE, 32'd38, e);
    check("input code 38 refused", e, 64'h1);
    write_reg(vio_pkg::IDX_VOUT_BASE, 32'd20, e);
    check("output code 20 refused", e, 64'h1);
    write_reg(vio_pkg::IDX_VIN_BASE + 6'h1, 32'd2, e);
    check("trigger 2 refused", e, 64'h1);
    write_reg(vio_pkg::IDX_VOUT_VIEW, 32'h1, e);
    check("view write refused", e, 64'h1);
    read_reg(6'h29, d, e);
    check("unmapped read error", e, 64'h1);
    check("unmapped read data", d, 64'h0);
    apb(1'b1, 8'h01, 32'h5, d, e);
    check("unaligned refused", e, 64'h1);
    read_reg(vio_pkg::IDX_VIN_BASE, d, e);
    check("refused writes change nothing", d, 64'h0);
    write_reg(vio_pkg::IDX_VIN_BASE + 6'h2, 32'd37, e);
    check("input code 37 accepted", e, 64'h0);
    write_reg(vio_pkg::IDX_VOUT_BASE, 32'd19, e);
    check("output code 19 accepted", e, 64'h0);
    read_reg(vio_pkg::IDX_VIN_BASE + 6'h2, d, e);
    check("input code readback", d, 64'd37);
    read_reg(vio_pkg::IDX_VIN_BASE + 6'h1e, d, e);
    check("input 16 function reachable", e, 64'h0);
  endtask

  task automatic test_level_trigger();
    logic e;
    // inputs 1 and 3 share code 5 so the or of both is seen
    write_reg(vio_pkg::IDX_VIN_BASE, 32'd5, e);
    write_reg(vio_pkg::IDX_VIN_BASE + 6'h4, 32'd5, e);
    repeat (4) @(posedge pclk);
    virtual_input[0] <= 1'b1;
    repeat (3) @(posedge pclk);
    check("level active", function_active[5], 64'h1);
    repeat (5) @(posedge pclk);
    check("level held", function_active[5], 64'h1);
    virtual_input[0] <= 1'b0;
    virtual_input[2] <= 1'b1;
    repeat (3) @(posedge pclk);
    check("shared code from input 3", function_active[5], 64'h1);
    virtual_input[2] <= 1'b0;
    repeat (3) @(posedge pclk);
    check("level released", function_active[5], 64'h0);
  endtask

  task automatic test_rise_trigger();
    logic e;
    int   n;
    n = 0;
    write_reg(vio_pkg::IDX_VIN_BASE + 6'h3, 32'h1, e);
    repeat (4) @(posedge pclk);
    check("no pulse while low", function_active[37], 64'h0);
    virtual_input[1] <= 1'b1;
    repeat (12) begin
      @(posedge pclk);
      if (function_active[37] === 1'b1) n++;
    end
    check("one pulse per rise", n, 64'd1);
    virtual_input[1] <= 1'b0;
    repeat (3) @(posedge pclk);
    check("no pulse on fall", function_active[37], 64'h0);
  endtask

  task automatic test_outputs();
    logic [31:0] d;
    logic        e;
    write_reg(vio_pkg::IDX_VOUT_BASE + 6'h2, 32'd19, e);
    write_reg(vio_pkg::IDX_VOUT_BASE + 6'h3, 32'h1, e);
    write_reg(vio_pkg::IDX_VOUT_BASE + 6'h4, 32'd3, e);
    write_reg(vio_pkg::IDX_VOUT_BASE + 6'h7, 32'h1, e);
    status_active[19] <= 1'b1;
    repeat (4) @(posedge pclk);
    check("outputs with code 19 active", virtual_output, 64'h9);
    read_reg(vio_pkg::IDX_VOUT_VIEW, d, e);
    check("view shows outputs", d, 64'h9);
    status_active[19] <= 1'b0;
    status_active[3]  <= 1'b1;
    repeat (4) @(posedge pclk);
    check("outputs with code 3 active", virtual_output, 64'he);
    status_active[3] <= 1'b0;
    repeat (4) @(posedge pclk);
    check("outputs all inactive", virtual_output, 64'ha);
  endtask

  task automatic test_frozen_while_running();
    logic [31:0] d;
    logic        e;
    drive_running <= 1'b1;
    repeat (2) @(posedge pclk);
    write_reg(vio_pkg::IDX_VOUT_BASE + 6'h1, 32'h1, e);
    check("write accepted while running", e, 64'h0);
    write_reg(vio_pkg::IDX_VIN_BASE, 32'h6, e);
    check("input write accepted while running", e, 64'h0);
    virtual_input[0] <= 1'b1;
    read_reg(vio_pkg::IDX_VOUT_BASE + 6'h1, d, e);
    check("written value reads back", d, 64'h1);
    read_reg(vio_pkg::IDX_STATUS, d, e);
    check("status running and pending", d,
          (64'h1 << vio_pkg::STAT_RUN_BIT) | (64'h1 << vio_pkg::STAT_PENDING_BIT));
    repeat (6) @(posedge pclk);
    check("output frozen while running", virtual_output, 64'ha);
    check("input keeps old code while running", function_active[5], 64'h1);
    check("input new code idle while running", function_active[6], 64'h0);
    drive_running <= 1'b0;
    repeat (4) @(posedge pclk);
    check("output applied after stop", virtual_output, 64'hb);
    check("input new code after stop", function_active[6], 64'h1);
    check("input old code dropped after stop", function_active[5], 64'h0);
    virtual_input[0] <= 1'b0;
    repeat (2) @(posedge pclk);
    read_reg(vio_pkg::IDX_STATUS, d, e);
    check("status clear after stop", d, 64'h0);
  endtask

  task automatic test_mid_reset();
    logic [31:0] d;
    logic        e;
    // a reset in mid-run must bring back every setting and output
    presetn <= 1'b0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    check("function_active after reset", function_active, 64'h0);
    check("virtual_output after reset", virtual_output, 64'h0);
    read_reg(vio_pkg::IDX_VIN_BASE, d, e);
    check("input code after reset", d, 64'h0);
    read_reg(vio_pkg::IDX_VOUT_BASE + 6'h1, d, e);
    check("output polarity after reset", d, 64'h0);
    read_reg(vio_pkg::IDX_STATUS, d, e);
    check("status after reset", d, 64'h0);
  endtask

  // ==========================================================================
  // main sequence
  initial begin
    pclk          = 1'b0;
    presetn       = 1'b0;
    psel          = 1'b0;
    penable       = 1'b0;
    pwrite        = 1'b0;
    paddr         = 8'h00;
    pwdata        = 32'h0;
    drive_running = 1'b0;
    virtual_input = 16'h0;
    status_active = 20'h0;
    n_errors      = 0;
    num_checks    = 0;
    cycles        = 0;
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    test_reset_values();
    test_refusals();
    test_level_trigger();
    test_rise_trigger();
    test_outputs();
    test_frozen_while_running();
    test_mid_reset();
    print_verdict();
  end
endmodule
